/* hdl/swm_master.sv */
// Single-wire bus master: reset/presence, byte write/read slots, overdrive and running CRC8/CRC16 reported to the user.
// Summary of operation
// R01: Master starts reset, write and read slots.
// R02: Overdrive timing applies to every waveform.
// R03: Reset of 640 us returns standard speed; the master keeps overdrive through any reset and clears it only on rst.
// R04: Overdrive reset stays short, keeping overdrive.
// R05: Device answers presence after high delay.
// R06: Sample presence at presence sample instant.
// R07: Reset high window covers presence plus recovery.
// R08: Reset high window 480 or 48 us.
// R09: Each slot carries exactly one bit.
// R10: Every slot begins with a falling edge.
// R11: Write one releases before maximum low time.
// R12: Write zero holds low minimum time.
// R13: Allow recovery after each slot.
// R14: Read slot starts like write one.
// R15: Device drives low for zero only.
// R16: Sample read late, then wait slot.
// R17: Running CRC8 x^8+x^5+x^4+1 over identifier.
// R18: CRC16 x^16+x^15+x^2+1 reported inverted.
// R19: Memory read CRC clears per pass.
// R20: Scratchpad write CRC covers command onward.
// R21: Scratchpad read CRC covers status too.
// R22: Checker compares CRC, user rereads on mismatch.
// R23: Overdrive skip command switches to overdrive.
// R24: Command bytes are eight bits.
// R25: Bits go least significant first.
module swm_master
	import swm_pkg::*;
#(
	parameter int RESET_LOW_CYC = STD_RESET_LOW_CYC,
	parameter int RESET_HIGH_CYC = STD_RESET_HIGH_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire swm_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output swm_rsp_t rsp,
	output logic overdrive,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_n
);
	typedef enum logic [2:0] {ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT, ST_DONE} swm_state_t;

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
		crc8_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC8_POLY_REV : 8'h00);
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
		crc16_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC16_POLY_REV : 16'h0000);
	endfunction

	function automatic logic [CNT_W-1:0] cyc(input int v);
		cyc = v[CNT_W-1:0];
	endfunction

	// Timing set selected by the speed flag.
	wire swm_timing_t tm_std = '{cyc(RESET_LOW_CYC), cyc(RESET_HIGH_CYC),
		cyc(STD_PRESENCE_SAMPLE_CYC), cyc(STD_SLOT_CYC), cyc(STD_WRITE_ZERO_LOW_CYC),
		cyc(STD_WRITE_ONE_LOW_CYC), cyc(STD_READ_SAMPLE_CYC), cyc(STD_RECOVERY_CYC)};
	wire swm_timing_t tm_od = '{cyc(OD_RESET_LOW_CYC), cyc(OD_RESET_HIGH_CYC),
		cyc(OD_PRESENCE_SAMPLE_CYC), cyc(OD_SLOT_CYC), cyc(OD_WRITE_ZERO_LOW_CYC),
		cyc(OD_WRITE_ONE_LOW_CYC), cyc(OD_READ_SAMPLE_CYC), cyc(OD_RECOVERY_CYC)};

	swm_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic rd_q;
	logic od_q;
	logic od_pend_q;
	logic pres_q;
	logic [7:0] crc8_q;
	logic [15:0] crc16_q;
	logic sync1_q, sync2_q;
	logic ready_q, valid_q, drive_q;

	wire swm_timing_t tm = od_q ? tm_od : tm_std; // R02
	wire logic line_s = sync2_q;
	wire logic cnt_end_rst_low = (cnt_q == tm.reset_low - 16'h0001);
	wire logic cnt_end_rst_high = (cnt_q == tm.reset_high - 16'h0001);
	wire logic cnt_end_slot = (cnt_q == tm.slot + tm.recovery - 16'h0001); // R13 R16
	wire logic pres_sample = (state_q == ST_RST_HIGH) && (cnt_q == tm.presence_sample); // R06
	wire logic rd_sample = (state_q == ST_SLOT) && rd_q && (cnt_q == tm.read_sample); // R16
	// A write one or read releases after the short low; a zero holds the long low.
	wire logic [CNT_W-1:0] low_len = (!rd_q && !sh_q[0]) ? tm.write_zero_low : tm.write_one_low;
	wire logic slot_drive = (cnt_q < low_len); // R11 R12 R14
	wire logic take = (state_q == ST_IDLE) && req_valid;
	// A read slot has already latched its sample into bit 0, and the line is back high by now.
	wire logic slot_bit = sh_q[0]; // R25
	wire logic byte_last = (bit_q == 3'd7);
	// Drive for the coming cycle: the counter restarts at a slot boundary.
	wire logic slot_drive_next = (state_q == ST_SLOT && cnt_end_slot) ||
		(cnt_q + 16'h0001 < low_len);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (req_valid) begin
					state_d = (req.op == SWM_OP_RESET) ? ST_RST_LOW : ST_SLOT; // R01
				end
			end
			ST_RST_LOW: if (cnt_end_rst_low) state_d = ST_RST_HIGH;
			ST_RST_HIGH: if (cnt_end_rst_high) state_d = ST_DONE; // R07 R08
			ST_SLOT: if (cnt_end_slot && byte_last) state_d = ST_DONE; // R09 R24
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= line_in;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			bit_q <= 3'd0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (take) begin
				cnt_q <= '0;
				bit_q <= 3'd0;
				sh_q <= req.data;
				rd_q <= (req.op == SWM_OP_READ_BYTE);
			end else if ((state_q == ST_RST_LOW && cnt_end_rst_low) ||
					(state_q == ST_SLOT && cnt_end_slot)) begin
				cnt_q <= '0;
				bit_q <= bit_q + 3'd1;
				sh_q <= {slot_bit, sh_q[7:1]}; // R25
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (rd_sample) begin
				sh_q[0] <= line_s; // R15
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			od_q <= 1'b0;
			od_pend_q <= 1'b0;
			pres_q <= 1'b0;
			crc8_q <= CRC8_RESET;
			crc16_q <= CRC16_RESET;
		end else begin
			if (take && req.crc_clear) begin
				crc8_q <= CRC8_RESET; // R19 R20 R21
				crc16_q <= CRC16_RESET;
			end else if (state_q == ST_SLOT && cnt_end_slot) begin
				crc8_q <= crc8_step(crc8_q, slot_bit); // R17
				crc16_q <= crc16_step(crc16_q, slot_bit); // R18
			end
			if (take && req.op == SWM_OP_WRITE_BYTE) begin
				od_pend_q <= (req.data == CMD_OVERDRIVE_SKIP);
			end
			if (state_q == ST_SLOT && cnt_end_slot && byte_last && od_pend_q && !rd_q) begin
				od_q <= 1'b1; // R23
				od_pend_q <= 1'b0;
			end
			if (state_q == ST_RST_LOW && cnt_end_rst_low && !od_q) begin
				od_q <= 1'b0; // R03 R04
			end
			if (pres_sample) begin
				pres_q <= !line_s; // R05 R06
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0;
			valid_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			ready_q <= (state_d == ST_IDLE) && !take;
			valid_q <= (state_q == ST_DONE);
			drive_q <= (state_d == ST_RST_LOW) ||
				((state_d == ST_SLOT) && (take ? 1'b1 : slot_drive_next)); // R10
		end
	end

	assign req_ready = ready_q;
	assign rsp_valid = valid_q;
	assign rsp = '{sh_q, pres_q, crc8_q, ~crc16_q}; // R18 R22
	assign overdrive = od_q;
	assign line_out = 1'b0;
	assign line_oe_n = !drive_q;

	property p_rst_low_drive;
		@(posedge clk_sys) disable iff (rst) (state_q == ST_RST_LOW) |-> !line_oe_n;
	endproperty
	a_rst_low_drive: assert property (p_rst_low_drive) // R01
		else $error("line not pulled low during reset low");

	property p_rst_high_release;
		@(posedge clk_sys) disable iff (rst) (state_q == ST_RST_HIGH) |-> line_oe_n;
	endproperty
	a_rst_high_release: assert property (p_rst_high_release) // R07
		else $error("line driven during reset high window");

	property p_slot_drive;
		@(posedge clk_sys) disable iff (rst) (state_q == ST_SLOT) |-> (line_oe_n == !slot_drive);
	endproperty
	a_slot_drive: assert property (p_slot_drive) // R11 R12 R14
		else $error("slot low phase has the wrong length");

	property p_read_release;
		@(posedge clk_sys) disable iff (rst)
			(state_q == ST_SLOT && rd_q && cnt_q >= tm.write_one_low) |-> line_oe_n;
	endproperty
	a_read_release: assert property (p_read_release) // R14
		else $error("read slot held low too long");

	property p_zero_hold;
		@(posedge clk_sys) disable iff (rst)
			(state_q == ST_SLOT && !rd_q && !sh_q[0] && cnt_q < tm.write_zero_low) |-> !line_oe_n;
	endproperty
	a_zero_hold: assert property (p_zero_hold) // R12
		else $error("write zero released early");

	property p_byte_done;
		@(posedge clk_sys) disable iff (rst)
			(state_q == ST_SLOT && cnt_end_slot && byte_last) |-> ##2 rsp_valid;
	endproperty
	a_byte_done: assert property (p_byte_done) // R09 R24
		else $error("no response after the eighth slot");

	property p_ready_idle;
		@(posedge clk_sys) disable iff (rst) req_ready |-> (state_q == ST_IDLE);
	endproperty
	a_ready_idle: assert property (p_ready_idle) // R01
		else $error("ready shown while busy");

	property p_rsp_pulse;
		@(posedge clk_sys) disable iff (rst) rsp_valid |=> !rsp_valid;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) // R09
		else $error("response valid longer than one cycle");
endmodule

/* common/swm_pkg.sv */
// Package of timing constants, commands and carrier types for the single-wire bus master.
package swm_pkg;
	localparam int CLK_MHZ = 50;
	// Standard speed times in microseconds.
	localparam int STD_RESET_LOW_US = 640;
	localparam int STD_RESET_HIGH_US = 480;
	localparam int STD_PRESENCE_SAMPLE_US = 70;
	localparam int STD_SLOT_US = 65;
	localparam int STD_WRITE_ZERO_LOW_US = 60;
	localparam int STD_WRITE_ONE_LOW_US = 6;
	localparam int STD_READ_SAMPLE_US = 12;
	localparam int STD_RECOVERY_US = 5;
	// Overdrive times in nanoseconds.
	localparam int OD_RESET_LOW_NS = 70000;
	localparam int OD_RESET_HIGH_NS = 48000;
	localparam int OD_PRESENCE_SAMPLE_NS = 10000;
	localparam int OD_SLOT_NS = 10000;
	localparam int OD_WRITE_ZERO_LOW_NS = 7000;
	localparam int OD_WRITE_ONE_LOW_NS = 1000;
	localparam int OD_READ_SAMPLE_NS = 2000;
	localparam int OD_RECOVERY_NS = 2000;
	localparam int STD_RESET_LOW_CYC = STD_RESET_LOW_US * CLK_MHZ;
	localparam int STD_RESET_HIGH_CYC = STD_RESET_HIGH_US * CLK_MHZ;
	localparam int STD_PRESENCE_SAMPLE_CYC = STD_PRESENCE_SAMPLE_US * CLK_MHZ;
	localparam int STD_SLOT_CYC = STD_SLOT_US * CLK_MHZ;
	localparam int STD_WRITE_ZERO_LOW_CYC = STD_WRITE_ZERO_LOW_US * CLK_MHZ;
	localparam int STD_WRITE_ONE_LOW_CYC = STD_WRITE_ONE_LOW_US * CLK_MHZ;
	localparam int STD_READ_SAMPLE_CYC = STD_READ_SAMPLE_US * CLK_MHZ;
	localparam int STD_RECOVERY_CYC = STD_RECOVERY_US * CLK_MHZ;
	localparam int OD_RESET_LOW_CYC = OD_RESET_LOW_NS * CLK_MHZ / 1000;
	localparam int OD_RESET_HIGH_CYC = OD_RESET_HIGH_NS * CLK_MHZ / 1000;
	localparam int OD_PRESENCE_SAMPLE_CYC = OD_PRESENCE_SAMPLE_NS * CLK_MHZ / 1000;
	localparam int OD_SLOT_CYC = OD_SLOT_NS * CLK_MHZ / 1000;
	localparam int OD_WRITE_ZERO_LOW_CYC = OD_WRITE_ZERO_LOW_NS * CLK_MHZ / 1000;
	localparam int OD_WRITE_ONE_LOW_CYC = OD_WRITE_ONE_LOW_NS * CLK_MHZ / 1000;
	localparam int OD_READ_SAMPLE_CYC = OD_READ_SAMPLE_NS * CLK_MHZ / 1000;
	localparam int OD_RECOVERY_CYC = OD_RECOVERY_NS * CLK_MHZ / 1000;
	localparam int CNT_W = 16;
	localparam logic [7:0] CMD_OVERDRIVE_SKIP = 8'h3C;
	localparam logic [7:0] CRC8_POLY_REV = 8'h8C;
	localparam logic [15:0] CRC16_POLY_REV = 16'hA001;
	localparam logic [7:0] CRC8_RESET = 8'h00;
	localparam logic [15:0] CRC16_RESET = 16'h0000;

	typedef enum logic [1:0] {
		SWM_OP_RESET,
		SWM_OP_WRITE_BYTE,
		SWM_OP_READ_BYTE
	} swm_op_t;

	typedef struct packed {
		swm_op_t op;
		logic [7:0] data;
		logic crc_clear;
	} swm_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic presence;
		logic [7:0] crc8;
		logic [15:0] crc16_inv;
	} swm_rsp_t;

	typedef struct packed {
		logic [CNT_W-1:0] reset_low;
		logic [CNT_W-1:0] reset_high;
		logic [CNT_W-1:0] presence_sample;
		logic [CNT_W-1:0] slot;
		logic [CNT_W-1:0] write_zero_low;
		logic [CNT_W-1:0] write_one_low;
		logic [CNT_W-1:0] read_sample;
		logic [CNT_W-1:0] recovery;
	} swm_timing_t;
endpackage

/* verif/swm_device_model.sv */
// Behavioural single-wire device: presence, write-slot sampling, read-slot answers, speed flag.
module swm_device_model
	import swm_pkg::*;
#(
	parameter int RST_DET = 3200,
	parameter int RST_EXIT = 3800
) (
	input wire logic clk_sys,
	input wire logic line,
	input wire logic present,
	input wire logic tx_en,
	input wire logic [7:0] tx_byte,
	output logic pull,
	output logic od,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_n = 0;
	int pres_t = 0;
	int t = 999999;
	int bitn = 0;
	logic prev = 1'b1;
	logic cur = 1'b1;
	initial begin
		pull = 1'b0;
		od = 1'b0;
		rx_byte = 8'h00;
	end
	// Counts are scaled to the shortened reset the bench gives the master.
	always @(posedge clk_sys) begin
		if (!line) begin
			low_n++;
		end else if (low_n > 0) begin
			if (low_n >= RST_DET) begin
				od = (low_n >= RST_EXIT) ? 1'b0 : od;
				pres_t = 1;
				bitn = 0;
			end
			low_n = 0;
		end
		if (pres_t > 0) begin
			pres_t++;
			pull <= present && pres_t > (od ? 100 : 1000) && pres_t <= (od ? 700 : 3750);
			if (pres_t > (od ? 700 : 3750)) pres_t = 0;
		end else begin
			if (prev && !line) begin
				t = 0;
				cur = tx_byte[bitn%8];
			end
			t++;
			if (t == (od ? 150 : 750)) begin
				rx_byte = {line, rx_byte[7:1]};
				bitn++;
				if (bitn == 8 && rx_byte == CMD_OVERDRIVE_SKIP) od = 1'b1;
			end
			pull <= tx_en && !cur && t < (od ? 150 : 1000);
		end
		prev = line;
	end
endmodule

/* verif/swm_master_test.sv */
// Self-checking bench for the single-wire bus master against the device model.
module swm_master_test;
	import swm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst = 1, req_valid = 0, present = 1, tx_en = 0;
	logic req_ready, rsp_valid, overdrive, line_out, line_oe_n, pull, od;
	swm_req_t req = '0;
	swm_rsp_t rsp, e;
	logic [7:0] tx_byte = 8'h00, rx_byte, seed = 8'h32, c8;
	logic [15:0] c16;
	int n_mismatch = 0, comparisons = 0, n_rsp = 0;
	swm_rsp_t exp_q[$], msk_q[$];
	// The pull-up wins unless someone sinks the line.
	wire logic line = (line_oe_n ? 1'b1 : line_out) & ~pull;
	always #10 clk_sys = ~clk_sys;
	swm_master #(.RESET_LOW_CYC(4000), .RESET_HIGH_CYC(4000)) i_dut (.clk_sys(clk_sys), .rst(rst),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
		.overdrive(overdrive), .line_in(line), .line_out(line_out), .line_oe_n(line_oe_n));
	swm_device_model i_dev (.clk_sys(clk_sys), .line(line), .present(present), .tx_en(tx_en),
		.tx_byte(tx_byte), .pull(pull), .od(od), .rx_byte(rx_byte));
	task check(input logic [32:0] seen, input logic [32:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task crc_byte(input logic [7:0] b);
		logic f8, f16;
		for (int i = 0; i < 8; i++) begin
			f8 = c8[0] ^ b[i];
			f16 = c16[0] ^ b[i];
			c8 = (c8 >> 1) ^ (f8 ? CRC8_POLY_REV : 8'h00);
			c16 = (c16 >> 1) ^ (f16 ? CRC16_POLY_REV : 16'h0000);
		end
	endtask
	task op(input swm_op_t o, input logic [7:0] d, input logic clr, input swm_rsp_t m);
		int n, k;
		n = n_rsp;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(negedge clk_sys);
		while (req_ready !== 1'b1) @(negedge clk_sys);
		req_valid = 1'b1;
		req = '{op: o, data: d, crc_clear: clr};
		@(negedge clk_sys);
		req_valid = 1'b0;
		k = 0;
		while (n_rsp == n && k < 40000) begin
			@(negedge clk_sys);
			k++;
		end
		check(33'(n_rsp - n), 33'h1, "no response");
	endtask
	always @(negedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			check(rsp & msk_q[0], exp_q[0] & msk_q[0], "response");
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
			n_rsp++;
		end
	end
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task do_reset(input logic p, input logic exp_od);
		present = p;
		e = '{data: 8'h00, presence: p, crc8: 8'h00, crc16_inv: 16'h0000};
		op(SWM_OP_RESET, 8'h00, 1'b0, '{data: 8'h00, presence: 1'b1, crc8: 8'h00, crc16_inv: 16'h0});
		check(33'({overdrive, od}), 33'({exp_od, exp_od}), "speed after reset");
		present = 1'b1;
	endtask
	task xfer(input logic rd, input logic clr, input logic [7:0] d);
		if (clr) {c8, c16} = 24'h000000;
		crc_byte(d);
		e = '{data: d, presence: 1'b0, crc8: c8, crc16_inv: ~c16};
		tx_byte = d;
		tx_en = rd;
		op(rd ? SWM_OP_READ_BYTE : SWM_OP_WRITE_BYTE, d, clr, '{data: {8{rd}}, presence: 1'b0,
			crc8: 8'hFF, crc16_inv: 16'hFFFF});
		tx_en = 1'b0;
		if (!rd) check(33'(rx_byte), 33'(d), "byte seen by device");
	endtask
	initial begin
		repeat (99000) @(posedge clk_sys);
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		do_reset(1'b1, 1'b0);
		do_reset(1'b0, 1'b0);
		$display("test standard reset done");
		xfer(1'b0, 1'b1, CMD_OVERDRIVE_SKIP);
		check(33'({overdrive, od}), 33'h3, "overdrive entry");
		do_reset(1'b1, 1'b1);
		$display("test overdrive entry done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			xfer(i[0], i == 0 || i == 3, seed);
		end
		$display("test overdrive bytes done");
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		do_reset(1'b1, 1'b0);
		$display("test speed exit done");
		final_report;
	end
endmodule
